// ===== vsirq_top.sv
// software bus interrupt, soft-acknowledge and ownership interrupt channel
`timescale 1ns/1ps
`default_nettype none
`include "vsirq_defs.svh"
module vsirq_top
    import vsirq_pkg::*;
#(
    parameter int NLINE = 8
) (
    input  wire logic             CORE_CLK,
    input  wire logic             RESETN,
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [11:0]      PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    input  wire logic [7:0]       OTHER_LEVEL_REQ,
    input  wire logic [7:0]       OTHER_STATID,
    input  wire logic             IACK_VALID,
    input  wire logic [2:0]       IACK_LEVEL,
    input  wire logic             BUS_ACQUIRED,
    output logic      [7:0]       BUS_IRQ_REQ,
    output logic      [7:0]       IACK_STATID,
    output logic                  IACK_DONE,
    output logic                  BUS_HOLD_REQ,
    output logic      [NLINE-1:0] LOCAL_IRQ_LINE,
    output logic                  IRQ
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic              bus_irq_enable_reg;
    logic              bus_irq_status_reg;
    vsirq_level_t      bus_irq_level_map;
    logic [1:0]        local_irq_enable_reg;
    logic [2:0]        local_irq_status_reg;
    logic [2:0]        local_irq_route_reg_b;
    logic              master_control_reg;
    logic [2:0]        irq_mask;
    logic [7:0]        soft_statid;
    logic [2:0]        events;
    vsirq_trig_t       trig_state;
    logic              own_armed;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
        reg_hit = (addr == off);
    endfunction
    wire         wr_acc    = PSEL && PENABLE && PWRITE;
    wire         rd_acc    = PSEL && PENABLE && !PWRITE;
    // read data launched in setup so it stands while pready is high
    wire         rd_setup  = PSEL && !PENABLE && !PWRITE;
    wire         hit_ben   = reg_hit(PADDR, `VSIRQ_OFF_BUS_EN);
    wire         hit_bst   = reg_hit(PADDR, `VSIRQ_OFF_BUS_STAT);
    wire         hit_bmap  = reg_hit(PADDR, `VSIRQ_OFF_BUS_MAP);
    wire         hit_len   = reg_hit(PADDR, `VSIRQ_OFF_LOC_EN);
    wire         hit_lst   = reg_hit(PADDR, `VSIRQ_OFF_LOC_STAT);
    wire         hit_lmap  = reg_hit(PADDR, `VSIRQ_OFF_LOC_MAP);
    wire         hit_mst   = reg_hit(PADDR, `VSIRQ_OFF_MASTER);
    wire         hit_mask  = reg_hit(PADDR, `VSIRQ_OFF_IRQ_MASK);
    wire         hit_sid   = reg_hit(PADDR, `VSIRQ_OFF_STATID);
    wire         hit_evt   = reg_hit(PADDR, `VSIRQ_OFF_EVENTS);
    wire         hit_any   = hit_ben | hit_bst | hit_bmap | hit_len | hit_lst | hit_lmap
                           | hit_mst | hit_mask | hit_sid | hit_evt;
    wire         trig_wr   = wr_acc && hit_ben;
    wire         trig_bit  = PWDATA[`VSIRQ_BIT_SOFT];

    // ------------------------------------------------------------
    // software bus interrupt
    // ------------------------------------------------------------
    logic [7:0]  soft_onehot;
    vsirq_level_dec u_dec (
        .level  (bus_irq_level_map),
        .enable (bus_irq_status_reg),
        .onehot (soft_onehot)
    );
    wire         ack_here  = IACK_VALID && (IACK_LEVEL == bus_irq_level_map);
    wire         soft_ack  = ack_here && bus_irq_status_reg;
    // soft status id always has bit zero low
    wire [7:0]   soft_id   = {soft_statid[7:1], 1'b0};
    wire         rise      = trig_wr && trig_bit && !bus_irq_enable_reg;
    // a rising write sets; acknowledge or disable removes
    wire         next_bstat = rise
                            || (bus_irq_status_reg && !soft_ack
                                && !(trig_wr && !trig_bit));
    wire         other_ack = IACK_VALID && OTHER_LEVEL_REQ[IACK_LEVEL];

    // ------------------------------------------------------------
    // local events: soft ack, ownership
    // ------------------------------------------------------------
    wire         own_evt   = own_armed && BUS_ACQUIRED;
    wire         sack_evt  = soft_ack && local_irq_enable_reg[0];
    wire [2:0]   loc_set   = {own_evt && local_irq_enable_reg[1], sack_evt, 1'b0};
    wire [2:0]   loc_clr   = (wr_acc && hit_lst) ? PWDATA[2:0] : 3'h0;
    logic [2:0]  loc_q;
    vsirq_evt_cap #(.W(3)) u_loc (
        .clk   (CORE_CLK),
        .rst_n (RESETN),
        .set   (loc_set),
        .clr   (loc_clr),
        .q     (loc_q)
    );
    wire         ack_line  = loc_q[`VSIRQ_BIT_SOFT_ACK];
    wire         own_line  = loc_q[`VSIRQ_BIT_OWN];
    wire [2:0]   evt_set   = {own_evt, soft_ack, rise};
    // a read clears only the bits it reported, so a later event is kept
    wire [2:0]   evt_done  = (rd_acc && hit_evt) ? PRDATA[2:0] : 3'h0;
    wire [2:0]   next_evt  = evt_set | (events & ~evt_done);

    logic [NLINE-1:0] next_lines;
    always_comb begin
        next_lines = '0;
        if (ack_line) next_lines[local_irq_route_reg_b[2:0]] = 1'b1;
        if (own_line) next_lines[0] = 1'b1;
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] rd_word;
    always_comb begin
        rd_word = `VSIRQ_RST_WORD;
        if (hit_ben)  rd_word[0]   = bus_irq_enable_reg;
        if (hit_bst)  rd_word[0]   = bus_irq_status_reg;
        if (hit_bmap) rd_word[2:0] = bus_irq_level_map;
        if (hit_len)  rd_word[2:1] = local_irq_enable_reg;
        if (hit_lst)  rd_word[2:0] = loc_q;
        if (hit_lmap) rd_word[2:0] = local_irq_route_reg_b;
        if (hit_mst)  rd_word[0]   = master_control_reg;
        if (hit_mask) rd_word[2:0] = irq_mask;
        if (hit_sid)  rd_word[7:0] = soft_statid;
        if (hit_evt)  rd_word[2:0] = events;
    end

    // ------------------------------------------------------------
    // sequential
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bus_irq_enable_reg    <= 1'b0;
            bus_irq_status_reg    <= 1'b0;
            bus_irq_level_map     <= 3'h0;
            local_irq_enable_reg  <= 2'h0;
            local_irq_route_reg_b <= 3'h0;
            master_control_reg    <= 1'b0;
            irq_mask              <= 3'h0;
            soft_statid           <= `VSIRQ_RST_STATID;
            events                <= 3'h0;
            own_armed             <= 1'b0;
            trig_state            <= VSIRQ_IDLE;
            PRDATA                <= 32'h00000000;
            PREADY                <= 1'b0;
            PSLVERR               <= 1'b0;
            BUS_IRQ_REQ           <= 8'h00;
            IACK_STATID           <= 8'h00;
            IACK_DONE             <= 1'b0;
            BUS_HOLD_REQ          <= 1'b0;
            LOCAL_IRQ_LINE        <= '0;
            IRQ                   <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !hit_any;
            if (rd_setup) PRDATA <= rd_word;
            if (trig_wr) bus_irq_enable_reg <= trig_bit;
            if (wr_acc && hit_bmap) bus_irq_level_map <= PWDATA[2:0];
            if (wr_acc && hit_len)  local_irq_enable_reg <= PWDATA[2:1];
            if (wr_acc && hit_lmap) local_irq_route_reg_b <= PWDATA[2:0];
            if (wr_acc && hit_mask) irq_mask <= PWDATA[2:0];
            if (wr_acc && hit_sid)  soft_statid <= PWDATA[7:0];
            if (wr_acc && hit_mst)  master_control_reg <= PWDATA[`VSIRQ_BIT_HOLD];
            if (wr_acc && hit_mst && PWDATA[`VSIRQ_BIT_HOLD] && !master_control_reg)
                own_armed <= 1'b1;
            else if (own_evt || !master_control_reg)
                own_armed <= 1'b0;
            bus_irq_status_reg <= next_bstat;
            events             <= next_evt;
            case (trig_state)
                VSIRQ_IDLE:     if (rise) trig_state <= VSIRQ_ASSERTED;
                VSIRQ_ASSERTED: if (!next_bstat) trig_state <= VSIRQ_WAIT_LOW;
                VSIRQ_WAIT_LOW: if (!bus_irq_enable_reg) trig_state <= VSIRQ_IDLE;
                default:        trig_state <= VSIRQ_IDLE;
            endcase
            BUS_IRQ_REQ  <= soft_onehot | OTHER_LEVEL_REQ;
            IACK_DONE    <= soft_ack || other_ack;
            if (soft_ack) IACK_STATID <= soft_id;
            else if (other_ack) IACK_STATID <= OTHER_STATID;
            BUS_HOLD_REQ   <= master_control_reg;
            LOCAL_IRQ_LINE <= next_lines;
            IRQ            <= |(next_evt & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_soft_first;
        @(posedge CORE_CLK) disable iff (!RESETN)
        soft_ack |=> IACK_STATID == $past(soft_id);
    endproperty
    a_soft_first: assert property (p_soft_first) else $error("soft id not chosen");
    property p_bit0;
        @(posedge CORE_CLK) disable iff (!RESETN)
        soft_ack |=> !IACK_STATID[0];
    endproperty
    a_bit0: assert property (p_bit0) else $error("soft id bit zero high");
    property p_roak;
        @(posedge CORE_CLK) disable iff (!RESETN)
        soft_ack && !rise |=> !bus_irq_status_reg ##1 (BUS_IRQ_REQ == $past(OTHER_LEVEL_REQ));
    endproperty
    a_roak: assert property (p_roak) else $error("soft request not withdrawn");
    property p_sack;
        @(posedge CORE_CLK) disable iff (!RESETN)
        sack_evt |=> ack_line;
    endproperty
    a_sack: assert property (p_sack) else $error("soft ack not latched");
    property p_line;
        @(posedge CORE_CLK) disable iff (!RESETN)
        sack_evt |=> ##1 LOCAL_IRQ_LINE[local_irq_route_reg_b];
    endproperty
    a_line: assert property (p_line) else $error("local line not raised");
    property p_own;
        @(posedge CORE_CLK) disable iff (!RESETN)
        own_evt && local_irq_enable_reg[1] |=> own_line;
    endproperty
    a_own: assert property (p_own) else $error("ownership not flagged");
    property p_clr;
        @(posedge CORE_CLK) disable iff (!RESETN)
        wr_acc && hit_lst && PWDATA[2] && !loc_set[2] |=> !own_line;
    endproperty
    a_clr: assert property (p_clr) else $error("ownership not cleared");
    property p_sticky;
        @(posedge CORE_CLK) disable iff (!RESETN)
        ack_line && !(wr_acc && hit_lst && PWDATA[1]) |=> ack_line;
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit lost");
    property p_once;
        @(posedge CORE_CLK) disable iff (!RESETN)
        rise |=> bus_irq_status_reg;
    endproperty
    a_once: assert property (p_once) else $error("trigger gave no interrupt");
    property p_disable;
        @(posedge CORE_CLK) disable iff (!RESETN)
        trig_wr && !trig_bit |=> !bus_irq_status_reg;
    endproperty
    a_disable: assert property (p_disable) else $error("disable kept interrupt");
    property p_single;
        @(posedge CORE_CLK) disable iff (!RESETN)
        rise |-> trig_state == VSIRQ_IDLE;
    endproperty
    a_single: assert property (p_single) else $error("second trigger while active");
    property p_level;
        @(posedge CORE_CLK) disable iff (!RESETN)
        bus_irq_status_reg |=> BUS_IRQ_REQ[$past(bus_irq_level_map)];
    endproperty
    a_level: assert property (p_level) else $error("request not on mapped level");
    property p_no_bus;
        @(posedge CORE_CLK) disable iff (!RESETN)
        !bus_irq_status_reg |=> BUS_IRQ_REQ == $past(OTHER_LEVEL_REQ);
    endproperty
    a_no_bus: assert property (p_no_bus) else $error("stray bus request");
    property p_other;
        @(posedge CORE_CLK) disable iff (!RESETN)
        other_ack && !soft_ack |=> IACK_STATID == $past(OTHER_STATID);
    endproperty
    a_other: assert property (p_other) else $error("other status id not given");
    property p_rd_lst;
        @(posedge CORE_CLK) disable iff (!RESETN)
        rd_setup && hit_lst |=> PRDATA[2:0] == $past(loc_q);
    endproperty
    a_rd_lst: assert property (p_rd_lst) else $error("local status read wrong");
    property p_ack_clr;
        @(posedge CORE_CLK) disable iff (!RESETN)
        wr_acc && hit_lst && PWDATA[1] && !loc_set[1] |=> !ack_line;
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("soft ack not cleared");

    // ------------------------------------------------------------
    // register bus checks
    // ------------------------------------------------------------
    property p_ready;
        @(posedge CORE_CLK) disable iff (!RESETN)
        PSEL && !PENABLE |=> PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready in access phase");
    property p_err;
        @(posedge CORE_CLK) disable iff (!RESETN)
        PSLVERR |-> PREADY;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
endmodule
`default_nettype wire

// ===== vsirq_defs.svh
// constants of the software and ownership interrupt block
`ifndef VSIRQ_DEFS_SVH
`define VSIRQ_DEFS_SVH
`define VSIRQ_OFF_BUS_EN     12'h000
`define VSIRQ_OFF_BUS_STAT   12'h004
`define VSIRQ_OFF_BUS_MAP    12'h008
`define VSIRQ_OFF_LOC_EN     12'h00C
`define VSIRQ_OFF_LOC_STAT   12'h010
`define VSIRQ_OFF_LOC_MAP    12'h014
`define VSIRQ_OFF_MASTER     12'h018
`define VSIRQ_OFF_IRQ_MASK   12'h01C
`define VSIRQ_OFF_STATID     12'h020
`define VSIRQ_OFF_EVENTS     12'h024
`define VSIRQ_BIT_SOFT       0
`define VSIRQ_BIT_SOFT_ACK   1
`define VSIRQ_BIT_OWN        2
`define VSIRQ_BIT_HOLD       0
`define VSIRQ_RST_WORD       32'h00000000
`define VSIRQ_RST_STATID     8'hFE
`endif

// ===== vsirq_pkg.sv
// types of the software and ownership interrupt block
package vsirq_pkg;
    typedef enum logic [1:0] {VSIRQ_IDLE, VSIRQ_ASSERTED, VSIRQ_WAIT_LOW} vsirq_trig_t;
    typedef logic [2:0] vsirq_level_t;
endpackage

// ===== vsirq_level_dec.sv
// one-hot decoder of a three-bit request level
`timescale 1ns/1ps
`default_nettype none
module vsirq_level_dec
    import vsirq_pkg::*;
(
    input  wire logic [2:0] level,
    input  wire logic       enable,
    output logic      [7:0] onehot
);
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            assign onehot[i] = enable && (level == 3'(i));
        end
    endgenerate
endmodule
`default_nettype wire

// ===== vsirq_evt_cap.sv
// sticky event capture with set winning over clear
`timescale 1ns/1ps
`default_nettype none
module vsirq_evt_cap #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= set | (q & ~clr);
        end
    end
endmodule
`default_nettype wire

// ===== vsirq_bus_model.sv
// bus side model: interrupt handler running acknowledge cycles and bus arbiter
`timescale 1ns/1ps
`default_nettype none
module vsirq_bus_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] irq_req,
    input  wire logic       hold,
    input  wire logic       go,
    input  wire logic [3:0] lag,
    output logic            iack_valid,
    output logic      [2:0] iack_level,
    output logic            acquired
);
    logic [3:0] cnt;
    logic [3:0] hcnt;
    logic       busy;
    // ----------------------------------------
    // highest requested level is acknowledged
    // ----------------------------------------
    function automatic logic [2:0] top(input logic [7:0] r);
        top = 3'h0;
        for (int i = 0; i < 8; i++) if (r[i]) top = i[2:0];
    endfunction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt        <= 4'h0;
            hcnt       <= 4'h0;
            busy       <= 1'b0;
            iack_valid <= 1'b0;
            iack_level <= 3'h0;
            acquired   <= 1'b0;
        end else begin
            iack_valid <= 1'b0;
            // level is not held once the cycle is over
            if (iack_valid) iack_level <= ~iack_level;
            if (go) begin
                busy <= 1'b1;
                cnt  <= lag;
            end else if (busy && cnt == 4'h0) begin
                busy       <= 1'b0;
                iack_valid <= 1'b1;
                iack_level <= top(irq_req);
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
            // bus granted some cycles after the hold request, kept while held
            hcnt     <= hold ? hcnt + {3'h0, hcnt != lag} : 4'h0;
            acquired <= hold && hcnt == lag;
        end
    end
endmodule
`default_nettype wire

// ===== vsirq_top_tb.sv
// self-checking bench of the software and ownership interrupt block
`timescale 1ns/1ps
`default_nettype none
module vsirq_top_tb;
    logic        CORE_CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [7:0]  OTHER_LEVEL_REQ, OTHER_STATID, BUS_IRQ_REQ, IACK_STATID, LOCAL_IRQ_LINE;
    logic [2:0]  IACK_LEVEL;
    logic        IACK_VALID, BUS_ACQUIRED, IACK_DONE, BUS_HOLD_REQ, IRQ, go;
    logic [3:0]  lag;
    logic [31:0] rd_q[$], id_q[$];
    int          n_mismatch, n_checks, cyc, lvl, rt;
    logic [7:0]  sid;
    vsirq_top #(.NLINE(8)) uut (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .OTHER_LEVEL_REQ(OTHER_LEVEL_REQ),
        .OTHER_STATID(OTHER_STATID), .IACK_VALID(IACK_VALID), .IACK_LEVEL(IACK_LEVEL),
        .BUS_ACQUIRED(BUS_ACQUIRED), .BUS_IRQ_REQ(BUS_IRQ_REQ), .IACK_STATID(IACK_STATID),
        .IACK_DONE(IACK_DONE), .BUS_HOLD_REQ(BUS_HOLD_REQ), .LOCAL_IRQ_LINE(LOCAL_IRQ_LINE),
        .IRQ(IRQ));
    vsirq_bus_model model (.clk(CORE_CLK), .rst_n(RESETN), .irq_req(BUS_IRQ_REQ),
        .hold(BUS_HOLD_REQ), .go(go), .lag(lag), .iack_valid(IACK_VALID),
        .iack_level(IACK_LEVEL), .acquired(BUS_ACQUIRED));
    // ----------------------------------------
    // clock, checks and bus tasks
    // ----------------------------------------
    initial begin
        CORE_CLK = 1'b0;
        forever #20 CORE_CLK = ~CORE_CLK;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches=%0d checks=%0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        if (!w) rd_q.push_back(d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= w ? d : 32'h0;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do @(posedge CORE_CLK); while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    task automatic w2();
        repeat (2) @(posedge CORE_CLK);
    endtask
    task automatic ack(input logic [7:0] e);
        id_q.push_back({24'h0, e});
        go <= 1'b1;
        lag <= 4'($urandom % 16);
        @(posedge CORE_CLK);
        go <= 1'b0;
        while (id_q.size() != 0) @(posedge CORE_CLK);
        w2();
    endtask
    always @(posedge CORE_CLK) begin
        cyc++;
        if (PSEL && PENABLE && PREADY === 1'b1) begin
            cmp(PSLVERR, PADDR > 12'h024);
            if (!PWRITE) cmp(PRDATA, rd_q.pop_front());
        end
        if (IACK_DONE === 1'b1) cmp(IACK_STATID, id_q.pop_front());
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {PSEL, PENABLE, PWRITE, go, PADDR, PWDATA, lag, OTHER_LEVEL_REQ, OTHER_STATID} = '0;
        RESETN = 1'b0;
        cyc = 0;
        void'($urandom(99891));
        repeat (3) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        @(posedge CORE_CLK);
        for (int a = 0; a <= 36; a += 4) apb(0, a[11:0], a == 32 ? 32'hFE : 32'h0);
        apb(0, 12'h030, 32'h0);
        lvl = 1 + $urandom % 7;
        rt = 1 + $urandom % 7;
        sid = 8'($urandom);
        apb(1, 12'h01C, 32'h7);
        apb(1, 12'h008, lvl);
        apb(1, 12'h020, {24'h0, sid});
        apb(1, 12'h00C, 32'h6);
        apb(1, 12'h014, rt);
        apb(1, 12'h000, 32'h1);
        w2();
        cmp(BUS_IRQ_REQ, 8'h1 << lvl);
        cmp(IRQ, 1'b1);
        apb(0, 12'h004, 32'h1);
        ack(sid & 8'hFE);
        cmp(BUS_IRQ_REQ, 8'h0);
        cmp(LOCAL_IRQ_LINE, 8'h1 << rt);
        apb(0, 12'h004, 32'h0);
        apb(0, 12'h024, 32'h3);
        w2();
        cmp(IRQ, 1'b0);
        OTHER_LEVEL_REQ <= 8'h1 << lvl;
        OTHER_STATID <= 8'($urandom) | 8'h1;
        apb(1, 12'h000, 32'h0);
        apb(1, 12'h000, 32'h1);
        ack(sid & 8'hFE);
        cmp(BUS_IRQ_REQ, 8'h1 << lvl);
        ack(OTHER_STATID);
        OTHER_LEVEL_REQ <= 8'h0;
        apb(1, 12'h000, 32'h0);
        apb(1, 12'h000, 32'h1);
        w2();
        cmp(BUS_IRQ_REQ, 8'h1 << lvl);
        apb(1, 12'h000, 32'h0);
        w2();
        cmp(BUS_IRQ_REQ, 8'h0);
        apb(1, 12'h01C, 32'h0);
        lag <= 4'($urandom % 16);
        apb(1, 12'h018, 32'h1);
        w2();
        cmp(BUS_HOLD_REQ, 1'b1);
        while (LOCAL_IRQ_LINE[0] !== 1'b1) @(posedge CORE_CLK);
        apb(0, 12'h010, 32'h6);
        cmp(IRQ, 1'b0);
        apb(1, 12'h01C, 32'h7);
        w2();
        cmp(IRQ, 1'b1);
        apb(0, 12'h024, 32'h7);
        w2();
        cmp(IRQ, 1'b0);
        apb(1, 12'h010, 32'h0);
        apb(0, 12'h010, 32'h6);
        apb(1, 12'h010, 32'h4);
        apb(0, 12'h010, 32'h2);
        apb(1, 12'h018, 32'h0);
        apb(1, 12'h010, 32'h2);
        apb(0, 12'h010, 32'h0);
        w2();
        cmp(LOCAL_IRQ_LINE, 8'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
